// File: rtl/swcpm_pkg.sv
/*
  Constants, mode codes and state encoding shared by the single-wire bus
  power-mode and protection controller.
  Assumes a single 100 MHz reference clock for every timing figure.
*/
package swcpm_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_MHZ         = 100;
  localparam int SLEEP_DELAY_MS  = 100;
  localparam int STANDBY_TIME_MS = 200;
  localparam int WAKE_FILTER_US  = 10;
  localparam int DEF_SLEEP_CYC   = SLEEP_DELAY_MS * 1000 * CLK_MHZ;
  localparam int DEF_STANDBY_CYC = STANDBY_TIME_MS * 1000 * CLK_MHZ;
  localparam int DEF_WAKE_CYC    = WAKE_FILTER_US * CLK_MHZ;

  // ==========================================================================
  // widths
  localparam int TMR_W  = 32;
  localparam int FILT_W = 16;

  // ==========================================================================
  // mode select codes, {mode_select_1, mode_select_0}
  localparam logic [1:0] MODE_SLEEP     = 2'h0;
  localparam logic [1:0] MODE_HIGH_SPD  = 2'h1;
  localparam logic [1:0] MODE_HV_WAKEUP = 2'h2;
  localparam logic [1:0] MODE_NORMAL    = 2'h3;

  // ==========================================================================
  // power state
  typedef enum logic [3:0]
  {
    ST_SLEEP   = 4'h1,
    ST_STANDBY = 4'h2,
    ST_ACTIVE  = 4'h4,
    ST_WAIT    = 4'h8
  } swcpm_state_t;

endpackage

// File: rtl/swcpm_timer.sv
/*
  Loadable down counter used as the standby sleep timer and as the
  sleep-entry delay. Counts only while run is high.
  Assumes load and run come from the controller in the same clock domain.
*/
module swcpm_timer
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        load,
  input  wire logic                        run,
  input  wire logic [swcpm_pkg::TMR_W-1:0] load_val,
  output logic                             done
);
  import swcpm_pkg::*;

  typedef struct packed
  {
    logic [TMR_W-1:0] cnt;
  } swcpm_tmr_st_t;

  swcpm_tmr_st_t s_r;
  swcpm_tmr_st_t s_nxt;

  // ==========================================================================
  // counter
  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.cnt = load_val;
    end
    else if (run && (s_r.cnt != '0))
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // no load term here: the controller ignores done in every cycle in which it loads
  assign done = run && (s_r.cnt == '0);

endmodule

// File: rtl/swcpm_wake_filter.sv
/*
  Wake-up filter: the high-voltage bus indication must stay present for
  more than the filter time before a wake-up is reported.
  Assumes hv_in is already synchronous to clk.
*/
module swcpm_wake_filter
#(
  parameter logic [swcpm_pkg::FILT_W-1:0] FILT_CYC = 16'h03E8
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hv_in,
  output logic      wake_lvl
);
  import swcpm_pkg::*;

  typedef struct packed
  {
    logic [FILT_W-1:0] cnt;
    logic              wake;
  } swcpm_filt_st_t;

  swcpm_filt_st_t s_r;
  swcpm_filt_st_t s_nxt;

  // ==========================================================================
  // filter; any gap in the traffic restarts the count
  always_comb
  begin
    s_nxt = s_r;
    if (!hv_in)
    begin
      s_nxt.cnt  = '0;
      s_nxt.wake = 1'b0;
    end
    else if (s_r.cnt == FILT_CYC)
    begin
      s_nxt.wake = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign wake_lvl = s_r.wake;

endmodule

// File: rtl/swcpm_top.sv
/*
  Power-mode and protection controller of a single-wire vehicle bus
  transceiver: standby and sleep timing, wake-up, regulator enable,
  under-voltage lock-out, thermal shutdown, short and loss-of-ground.
  Assumes all analog detectors arrive as clean levels synchronous to
  REF_CLK (100 MHz) and that the bus pin is resolved outside from the
  output and its enable.
*/
module swcpm_top
#(
  parameter int SLEEP_DELAY_CYC = swcpm_pkg::DEF_SLEEP_CYC,
  parameter int STANDBY_CYC     = swcpm_pkg::DEF_STANDBY_CYC,
  parameter int WAKE_FILTER_CYC = swcpm_pkg::DEF_WAKE_CYC
)
(
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  input  wire logic TX_DOMINANT_N,
  input  wire logic MODE_SELECT_0,
  input  wire logic MODE_SELECT_1,
  input  wire logic SUPPLY_UVLO,
  input  wire logic SUPPLY_LOW_BAND,
  input  wire logic OVER_TEMP,
  input  wire logic BUS_SHORT_GND,
  input  wire logic LOSS_OF_GROUND,
  input  wire logic BUS_LINE_SENSE,
  input  wire logic BUS_HV_SENSE,
  output logic      BUS_LINE_DRV,
  output logic      BUS_LINE_OE,
  output logic      BUS_HV_LEVEL,
  output logic      BUS_CURRENT_LIMIT,
  output logic      RX_DATA,
  output logic      REGULATOR_ENABLE_OUT,
  output logic      LOAD_GND_EN
);
  import swcpm_pkg::*;

  localparam logic [TMR_W-1:0]  SLEEP_VAL   = TMR_W'(SLEEP_DELAY_CYC);
  localparam logic [TMR_W-1:0]  STANDBY_VAL = TMR_W'(STANDBY_CYC);
  localparam logic [FILT_W-1:0] WAKE_VAL    = FILT_W'(WAKE_FILTER_CYC);

  typedef struct packed
  {
    swcpm_state_t st;
    logic         por;
    logic         reg_en;
    logic         drive;
    logic         hv_level;
    logic         ilim;
    logic         rx;
    logic         load_en;
  } swcpm_top_st_t;

  swcpm_top_st_t    s_r;
  swcpm_top_st_t    s_nxt;
  logic [1:0]       mode;
  logic             mode_act;
  logic             drive_req;
  logic             tmr_load;
  logic             tmr_run;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;
  logic             wake_lvl;

  // ==========================================================================
  // timers
  swcpm_timer u_timer
  (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .load     (tmr_load),
    .run      (tmr_run),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  swcpm_wake_filter #(.FILT_CYC(WAKE_VAL)) u_wake
  (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .hv_in    (BUS_HV_SENSE),
    .wake_lvl (wake_lvl)
  );

  // ==========================================================================
  // mode decode and transmit qualification
  assign mode     = {MODE_SELECT_1, MODE_SELECT_0};
  assign mode_act = (mode != MODE_SLEEP);
  // loss of ground deliberately does not gate the driver
  assign drive_req = mode_act && !TX_DOMINANT_N && !SUPPLY_UVLO && !OVER_TEMP;

  // ==========================================================================
  // next state
  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.por = 1'b0;
    tmr_load  = 1'b0;
    tmr_val   = STANDBY_VAL;
    case (s_r.st)
      ST_STANDBY:
      begin
        if (mode_act)
          s_nxt.st = ST_ACTIVE;
        else if (!s_r.por && tmr_done)
          s_nxt.st = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (mode_act)
          s_nxt.st = ST_ACTIVE;
        else if (wake_lvl)
          s_nxt.st = ST_STANDBY;
      end
      ST_ACTIVE:
      begin
        if (!mode_act)
          s_nxt.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (mode_act)
          s_nxt.st = ST_ACTIVE;
        else if (wake_lvl)
          s_nxt.st = ST_STANDBY;
        else if (!BUS_HV_SENSE && tmr_done)
          s_nxt.st = ST_SLEEP;
      end
      default:
      begin
        s_nxt.st = ST_STANDBY;
      end
    endcase

    // standby timer starts at power-on and on every standby entry
    if (s_r.por || ((s_nxt.st == ST_STANDBY) && (s_r.st != ST_STANDBY)))
    begin
      tmr_load = 1'b1;
      tmr_val  = STANDBY_VAL;
    end
    else if ((s_nxt.st == ST_WAIT) && ((s_r.st != ST_WAIT) || BUS_HV_SENSE))
    begin
      // wake-up activity restarts the delay so it never ends early
      tmr_load = 1'b1;
      tmr_val  = SLEEP_VAL;
    end

    s_nxt.reg_en   = (s_nxt.st != ST_SLEEP);
    s_nxt.drive    = drive_req;
    s_nxt.hv_level = drive_req && (mode == MODE_HV_WAKEUP) && !SUPPLY_LOW_BAND;
    s_nxt.ilim     = drive_req && BUS_SHORT_GND;
    s_nxt.load_en  = !LOSS_OF_GROUND;
    if (SUPPLY_UVLO)
      s_nxt.rx = 1'b1;
    else if (mode_act)
      s_nxt.rx = !BUS_LINE_SENSE;
    else
      s_nxt.rx = !wake_lvl;
  end

  // stopped in every active mode
  assign tmr_run = (s_r.st == ST_STANDBY) || (s_r.st == ST_WAIT);

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      s_r          <= '0;
      s_r.st       <= ST_STANDBY;
      s_r.por      <= 1'b1;
      s_r.reg_en   <= 1'b1;
      s_r.rx       <= 1'b1;
      s_r.load_en  <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign BUS_LINE_DRV         = s_r.drive;
  assign BUS_LINE_OE          = s_r.drive;
  assign BUS_HV_LEVEL         = s_r.hv_level;
  assign BUS_CURRENT_LIMIT    = s_r.ilim;
  assign RX_DATA              = s_r.rx;
  assign REGULATOR_ENABLE_OUT = s_r.reg_en;
  assign LOAD_GND_EN          = s_r.load_en;

  // ==========================================================================
  // checks
  // helper counters: delay and filter spans are too long for a repetition
  logic [TMR_W-1:0] wait_cnt_r;
  logic [TMR_W-1:0] hv_run_r;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      wait_cnt_r <= '0;
    else if (s_r.st == ST_WAIT)
      wait_cnt_r <= wait_cnt_r + 1'b1;
    else
      wait_cnt_r <= '0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      hv_run_r <= '0;
    else if (BUS_HV_SENSE)
      hv_run_r <= hv_run_r + 1'b1;
    else
      hv_run_r <= '0;
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  uvlo_quiet_a: assert property (SUPPLY_UVLO |=> !BUS_LINE_OE && RX_DATA)
    else $error("bus driven or receive low under lock-out");

  low_band_a: assert property ((mode == MODE_HV_WAKEUP) && SUPPLY_LOW_BAND |=> !BUS_HV_LEVEL)
    else $error("high-voltage level driven in reduced supply band");

  por_standby_a: assert property (!$past(RST_N) |-> (s_r.st == ST_STANDBY) && REGULATOR_ENABLE_OUT
    ##1 (tmr_run || (s_r.st == ST_ACTIVE)))
    else $error("no standby with regulator enable after power-on");

  standby_expire_a: assert property ((s_r.st == ST_STANDBY) && !s_r.por && tmr_done && !mode_act
    |=> (s_r.st == ST_SLEEP) && !REGULATOR_ENABLE_OUT)
    else $error("standby expiry did not release regulator");

  wake_standby_a: assert property ((s_r.st == ST_SLEEP) && wake_lvl && !mode_act
    |=> REGULATOR_ENABLE_OUT && (s_r.st == ST_STANDBY) ##1 ((tmr_run && !tmr_done) || (s_r.st == ST_ACTIVE)))
    else $error("wake-up did not restart standby");

  active_hold_a: assert property (mode_act && (s_r.st != ST_ACTIVE)
    |=> ((s_r.st == ST_ACTIVE) && REGULATOR_ENABLE_OUT && !tmr_run) ##1 REGULATOR_ENABLE_OUT)
    else $error("active mode did not stop timer or hold regulator");

  sleep_delay_a: assert property ($fell(REGULATOR_ENABLE_OUT) && ($past(s_r.st) == ST_WAIT)
    |-> wait_cnt_r > SLEEP_VAL)
    else $error("regulator released before sleep delay");

  thermal_off_a: assert property (OVER_TEMP |=> !BUS_LINE_OE && !BUS_CURRENT_LIMIT)
    else $error("transmitter active during thermal shutdown");

  thermal_recover_a: assert property (OVER_TEMP ##1 (!OVER_TEMP && drive_req) |=> BUS_LINE_OE && BUS_LINE_DRV)
    else $error("transmitter not restored after thermal recovery");

  short_limit_a: assert property (drive_req && BUS_SHORT_GND |=> BUS_CURRENT_LIMIT && BUS_LINE_OE)
    else $error("short to ground without current limit");

  ground_loss_a: assert property (LOSS_OF_GROUND |=> !LOAD_GND_EN)
    else $error("load switch not opened on loss of ground");

  ground_tx_a: assert property (LOSS_OF_GROUND && drive_req |=> BUS_LINE_OE)
    else $error("transmission stopped on loss of ground");

  mode_level_a: assert property (drive_req && !SUPPLY_LOW_BAND
    |=> BUS_HV_LEVEL == ($past(mode) == MODE_HV_WAKEUP))
    else $error("drive level does not follow mode select");

  sleep_rx_a: assert property (!mode_act && !SUPPLY_UVLO |=> !BUS_LINE_OE && (RX_DATA == !$past(wake_lvl)))
    else $error("sleep output not limited to wake-up");

  uvlo_no_level_a: assert property (SUPPLY_UVLO |=> !BUS_HV_LEVEL && !BUS_CURRENT_LIMIT)
    else $error("high-voltage level or current limit under lock-out");

  sleep_reg_off_a: assert property ((s_r.st == ST_SLEEP) |-> !REGULATOR_ENABLE_OUT)
    else $error("regulator enabled in sleep");

  wait_hold_a: assert property ((s_r.st == ST_WAIT) && !mode_act && !wake_lvl && !tmr_done
    |=> (s_r.st == ST_WAIT) && REGULATOR_ENABLE_OUT)
    else $error("regulator released while sleep delay runs");

  wait_reload_a: assert property ((s_r.st == ST_WAIT) && BUS_HV_SENSE && !mode_act && !wake_lvl
    |=> (s_r.st == ST_WAIT) && !tmr_done)
    else $error("wake-up activity did not restart sleep delay");

  wake_filter_a: assert property ($rose(wake_lvl) |-> hv_run_r > TMR_W'(WAKE_VAL))
    else $error("wake-up reported before filter time");

  wake_seq_c: cover property ((s_r.st == ST_SLEEP) ##1 (s_r.st == ST_STANDBY) ##1 (s_r.st == ST_ACTIVE));
  expire_c: cover property ((s_r.st == ST_STANDBY) ##1 (s_r.st == ST_SLEEP));
  wait_sleep_c: cover property ((s_r.st == ST_WAIT) ##1 (s_r.st == ST_SLEEP));
  thermal_c: cover property (BUS_LINE_OE ##1 OVER_TEMP ##1 !BUS_LINE_OE ##[1:20] BUS_LINE_OE);
  hv_reload_c: cover property ((s_r.st == ST_WAIT) && BUS_HV_SENSE ##1 (s_r.st == ST_WAIT));

endmodule

// File: tb/swcpm_host_model.sv
/*
  Host microcontroller model: drives the two mode-select inputs and the
  transmit input of the power-mode controller from bench requests.
  Assumes requests arrive synchronous to clk; outputs are registered.
*/
module swcpm_host_model
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] mode_req,
  input  wire logic       tx_req_n,
  output logic            mode_sel_0,
  output logic            mode_sel_1,
  output logic            tx_dom_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // pin drive
  // undriven pins read as sleep and recessive, so reset mirrors that
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_sel_0 <= 1'b0;
      mode_sel_1 <= 1'b0;
      tx_dom_n   <= 1'b1;
    end
    else
    begin
      mode_sel_0 <= mode_req[0];
      mode_sel_1 <= mode_req[1];
      tx_dom_n   <= tx_req_n;
    end
  end
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench of the power-mode controller with a cycle model of
  the bus, receive and load-ground outputs and timed regulator checks.
  Assumes shortened timer parameters and a 100 MHz reference clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import swcpm_pkg::*;

  localparam int SLP = 20;
  localparam int STB = 30;
  localparam int WF  = 4;

  logic        clk;
  logic        rst_n;
  logic [1:0]  mode_req;
  logic        tx_req_n, uvlo, lowb, otemp, shrt, lgnd, line_i, hv_i;
  logic        m0, m1, txn;
  logic        bo, boe, bhv, bcl, rx, reg_en, lgen;
  logic        e_o, e_hv, e_cl, e_rx, e_lg, rx_ok, armed;
  logic [31:0] rnd;
  int          bad_count, compares, seed, quiet;
  logic [1:0]  md;
  logic        dq;

  assign md = {m1, m0};
  assign dq = md != MODE_SLEEP && !txn && !uvlo && !otemp;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  swcpm_host_model u_swcpm_host_model
  (
    .clk(clk), .rst_n(rst_n), .mode_req(mode_req), .tx_req_n(tx_req_n),
    .mode_sel_0(m0), .mode_sel_1(m1), .tx_dom_n(txn)
  );

  swcpm_top #(.SLEEP_DELAY_CYC(SLP), .STANDBY_CYC(STB), .WAKE_FILTER_CYC(WF)) u_swcpm_top
  (
    .REF_CLK(clk), .RST_N(rst_n), .TX_DOMINANT_N(txn), .MODE_SELECT_0(m0),
    .MODE_SELECT_1(m1), .SUPPLY_UVLO(uvlo), .SUPPLY_LOW_BAND(lowb),
    .OVER_TEMP(otemp), .BUS_SHORT_GND(shrt), .LOSS_OF_GROUND(lgnd),
    .BUS_LINE_SENSE(line_i), .BUS_HV_SENSE(hv_i), .BUS_LINE_DRV(bo), .BUS_LINE_OE(boe),
    .BUS_HV_LEVEL(bhv), .BUS_CURRENT_LIMIT(bcl), .RX_DATA(rx),
    .REGULATOR_ENABLE_OUT(reg_en), .LOAD_GND_EN(lgen)
  );

  // ==========================================================================
  // compare and verdict
  task automatic chk(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // waits for the regulator (sel 0) or receive output to reach v
  task automatic wait_lvl(input int sel, input logic v, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((sel == 0 ? reg_en : rx) !== v && n <= hi);
    chk(nm, 1'b1, n >= lo && n <= hi);
  endtask

  // ==========================================================================
  // cycle model: outputs follow inputs of the previous edge
  always @(posedge clk)
  begin
    armed <= rst_n;
    quiet <= hv_i ? 0 : quiet + 1;
    e_o   <= dq;
    e_hv  <= dq && md == MODE_HV_WAKEUP && !lowb;
    e_cl  <= dq && shrt;
    e_lg  <= !lgnd;
    e_rx  <= uvlo ? 1'b1 : (md != MODE_SLEEP ? !line_i : 1'b1);
    // outside active modes the receive output is only known once the wake filter has emptied
    rx_ok <= uvlo || md != MODE_SLEEP || quiet >= 3;
  end

  always @(negedge clk)
  begin
    if (armed)
    begin
      chk("bus_out", e_o, bo);
      chk("bus_oe", e_o, boe);
      chk("hv_level", e_hv, bhv);
      chk("cur_limit", e_cl, bcl);
      chk("load_gnd", e_lg, lgen);
      if (rx_ok)
        chk("rx", e_rx, rx);
    end
  end

  // ==========================================================================
  // scenarios
  initial
  begin
    seed = 40;
    bad_count = 0;
    compares = 0;
    quiet = 0;
    armed = 1'b0;
    rst_n = 1'b0;
    mode_req = MODE_SLEEP;
    {tx_req_n, uvlo, lowb, otemp, shrt, lgnd, line_i, hv_i} = 8'h80;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reg_on", 1'b1, reg_en);
    wait_lvl(0, 1'b0, STB, STB + 5, "standby_end");
    @(posedge clk);
    hv_i <= 1'b1;
    // exactly the filter time is still too short: it must be exceeded
    repeat (WF) @(posedge clk);
    hv_i <= 1'b0;
    repeat (6) @(negedge clk);
    chk("short_burst", 1'b0, reg_en);
    @(posedge clk);
    hv_i <= 1'b1;
    wait_lvl(0, 1'b1, WF, WF + 5, "wake_reg");
    chk("wake_rx", 1'b0, rx);
    @(posedge clk);
    hv_i <= 1'b0;
    wait_lvl(0, 1'b0, STB - 2, STB + 5, "restandby");
    @(posedge clk);
    mode_req <= MODE_NORMAL;
    wait_lvl(0, 1'b1, 1, 6, "active_on");
    repeat (2 * STB)
    begin
      @(negedge clk);
      chk("active_hold", 1'b1, reg_en);
    end
    // every mode code and fault mix, wake line kept quiet
    repeat (400)
    begin
      @(posedge clk);
      rnd = $random(seed);
      mode_req <= rnd[1:0];
      tx_req_n <= rnd[2];
      uvlo     <= rnd[4:3] == 2'h0;
      lowb     <= rnd[5];
      otemp    <= rnd[7:6] == 2'h0;
      shrt     <= rnd[8];
      lgnd     <= rnd[9];
      line_i   <= rnd[10];
    end
    @(posedge clk);
    {uvlo, otemp, tx_req_n} <= 3'h1;
    mode_req <= MODE_NORMAL;
    repeat (10) @(posedge clk);
    mode_req <= MODE_SLEEP;
    // one host cycle to reach the pins, one edge to enter the delay, one edge to leave it
    wait_lvl(0, 1'b0, SLP + 3, SLP + 5, "sleep_delay");
    @(posedge clk);
    mode_req <= MODE_NORMAL;
    repeat (4) @(posedge clk);
    mode_req <= MODE_SLEEP;
    repeat (10) @(posedge clk);
    // one-cycle wake-up activity in the delay: too short to wake, restarts the delay
    hv_i <= 1'b1;
    @(posedge clk);
    hv_i <= 1'b0;
    wait_lvl(0, 1'b0, SLP + 1, SLP + 5, "hv_restart");
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule
